// >>> hvt_pkg.sv
// Constants and types for the horizontal and vertical raster timing block
package hvt_pkg;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef logic [7:0]  hvt_byte_type;
	typedef logic [15:0] hvt_addr_type;
	typedef logic [8:0]  hvt_hcnt_type;
	typedef logic [10:0] hvt_vcnt_type;

	// ----------------------------------------------------------------
	// I/O decode
	// ----------------------------------------------------------------
	localparam logic [11:0] HVT_BASE_MONO  = 12'h03B;
	localparam logic [11:0] HVT_BASE_COLOR = 12'h03D;
	localparam logic [3:0]  HVT_PORT_INDEX = 4'h4;
	localparam logic [3:0]  HVT_PORT_DATA  = 4'h5;
	localparam hvt_byte_type HVT_INDEX_RST = 8'h00;
	localparam hvt_byte_type HVT_REG_RST   = 8'h00;

	// ----------------------------------------------------------------
	// Register indices
	// ----------------------------------------------------------------
	localparam hvt_byte_type HVT_IDX_HTOT  = 8'h00;
	localparam hvt_byte_type HVT_IDX_HDE   = 8'h01;
	localparam hvt_byte_type HVT_IDX_HBS   = 8'h02;
	localparam hvt_byte_type HVT_IDX_HBE   = 8'h03;
	localparam hvt_byte_type HVT_IDX_HSS   = 8'h04;
	localparam hvt_byte_type HVT_IDX_HSE   = 8'h05;
	localparam hvt_byte_type HVT_IDX_VTOT  = 8'h06;
	localparam hvt_byte_type HVT_IDX_OVFL  = 8'h07;
	localparam hvt_byte_type HVT_IDX_LAST  = 8'h07;
	localparam int           HVT_NUM_REGS  = 8;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int HVT_HX_HTOT8  = 0;
	localparam int HVT_HX_HDE8   = 1;
	localparam int HVT_HX_HBS8   = 2;
	localparam int HVT_HX_BSTR   = 3;
	localparam int HVT_HX_HSS8   = 4;
	localparam int HVT_HX_SSTR   = 5;
	localparam int HVT_VX_VTOT10 = 0;
	localparam int HVT_VX_VRS10  = 4;
	localparam int HVT_OV_VTOT8  = 0;
	localparam int HVT_OV_VRS8   = 2;
	localparam int HVT_OV_VTOT9  = 5;
	localparam int HVT_OV_VRS9   = 7;
	localparam int HVT_HBE_B5    = 7;
	localparam int HVT_SKEW_LSB  = 5;

	// ----------------------------------------------------------------
	// Timing constants
	// ----------------------------------------------------------------
	localparam int           HVT_CHAR_PIX  = 8;
	localparam logic [2:0]   HVT_PIX_LAST  = 3'(HVT_CHAR_PIX - 1);
	localparam logic [9:0]   HVT_HTOT_ADJ  = 10'h004;
	localparam logic [11:0]  HVT_VTOT_ADJ  = 12'h001;
	localparam int           HVT_BLANK_STR = 64;
	localparam int           HVT_SYNC_STR  = 32;

endpackage : hvt_pkg

// >>> hvt_timing.sv
// Raster timing: indexed register port, counters, sync/blank/enable
// How it works
// - Index port written first; data port reaches register the index selects.
// - Port pair decodes at mono or colour base per misc output bit 0.
// - Eight-bit readable index, zero after reset, full value selects target.
// - Indices beyond local range flagged so extension registers answer instead.
// - Horizontal total nine bits, chars per line minus five, bit8 extension.
// - Display end nine bits, active chars minus one, bit8 extension bit1.
// - Blank starts when char counter equals nine-bit start value.
// - Blank ends on six-bit match of counter low bits.
// - Extension bit3 stretches blank by 64 pixel clocks.
// - Display enable delayed zero to three character clocks.
// - Sync starts when char counter equals nine-bit start value.
// - Sync ends on five-bit match of counter low bits.
// - Extension bit5 stretches sync by 32 pixel clocks.
// - Sync output delayed zero to three character clocks.
// - Eleven-bit vertical total, lines minus two; line counter wraps.
// - Vertical total bits from index 06, overflow 0 and 5, extension 0.
// - Overflow register supplies upper bits of vertical fields.
// - Vertical sync starts when line counter equals eleven-bit start.

// --------------------------------------------------------------------
// Pulse generator: start match, end match, optional pixel stretch
// --------------------------------------------------------------------
module hvt_pulse #(
	parameter int EW  = 6,
	parameter int STR = 64
) (
	input  wire logic          clk_i,
	input  wire logic          rst_n_i,
	input  wire logic          char_en_i,
	input  wire logic          pix_en_i,
	input  wire logic [8:0]    cnt_i,
	input  wire logic [8:0]    start_i,
	input  wire logic [EW-1:0] end_i,
	input  wire logic          stretch_i,
	output logic               pulse_o
);
	localparam logic [6:0] STR_LAST = 7'(STR - 1);
	logic       active_ff;
	logic       str_ff;
	logic [6:0] str_cnt_ff;

	// Start wins over end so a zero-width setting still yields a pulse
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			active_ff  <= 1'b0;
			str_ff     <= 1'b0;
			str_cnt_ff <= 7'h00;
		end else if (char_en_i && cnt_i == start_i) begin
			active_ff  <= 1'b1;
			str_ff     <= 1'b0;
		end else if (str_ff) begin
			if (pix_en_i) begin
				str_cnt_ff <= str_cnt_ff - 7'h01;
				if (str_cnt_ff == 7'h00) begin
					active_ff <= 1'b0;
					str_ff    <= 1'b0;
				end
			end
		end else if (active_ff && char_en_i && cnt_i[EW-1:0] == end_i) begin
			if (stretch_i) begin
				str_ff     <= 1'b1; // extra pixel clocks after end
				str_cnt_ff <= STR_LAST;
			end else begin
				active_ff  <= 1'b0;
			end
		end
	end

	assign pulse_o = active_ff;
endmodule : hvt_pulse

// --------------------------------------------------------------------
// Skew line: delays a level by 0..3 character clocks
// --------------------------------------------------------------------
module hvt_skew (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       char_en_i,
	input  wire logic       d_i,
	input  wire logic [1:0] sel_i,
	output logic            q_o
);
	logic [2:0] tap_ff;
	logic [3:0] taps;
	logic       q_ff;

	// Select zero bypasses the taps, so encoding 00 adds no char delay
	assign taps = {tap_ff, d_i};

	// Taps move only on character clocks, so skew is in chars
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			tap_ff <= 3'h0;
			q_ff   <= 1'b0;
		end else begin
			if (char_en_i) begin
				tap_ff <= {tap_ff[1:0], d_i};
			end
			q_ff <= taps[sel_i];
		end
	end

	assign q_o = q_ff;
endmodule : hvt_skew

// --------------------------------------------------------------------
// Top
// --------------------------------------------------------------------
module hvt_timing (
	// Clock and reset
	input  wire logic            SYS_CLK_I,
	input  wire logic            RST_N_I,
	// Host I/O port
	input  wire hvt_pkg::hvt_addr_type IO_ADDR_I,
	input  wire logic            IO_WR_I,
	input  wire logic            IO_RD_I,
	input  wire hvt_pkg::hvt_byte_type IO_WDATA_I,
	output hvt_pkg::hvt_byte_type      IO_RDATA_O,
	output logic                 IO_RD_HIT_O,
	output logic                 EXT_IDX_SEL_O,
	output hvt_pkg::hvt_byte_type      EXT_INDEX_O,
	// Bits kept by neighbouring registers
	input  wire logic            MISC_COLOR_SEL_I,
	input  wire hvt_pkg::hvt_byte_type HORIZ_EXT_I,
	input  wire hvt_pkg::hvt_byte_type VERT_EXT_I,
	input  wire hvt_pkg::hvt_byte_type VSYNC_START_LO_I,
	input  wire logic [3:0]      VSYNC_END_I,
	// Pixel clock enable
	input  wire logic            PIXEL_CLK_EN_I,
	// Monitor timing
	output logic                 HSYNC_O,
	output logic                 HBLANK_O,
	output logic                 DISP_EN_O,
	output logic                 VSYNC_O,
	output hvt_pkg::hvt_hcnt_type      CHAR_CNT_O,
	output hvt_pkg::hvt_vcnt_type      LINE_CNT_O
);
	import hvt_pkg::*;

	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	hvt_byte_type idx_ff;
	hvt_byte_type regs_ff [HVT_NUM_REGS];
	hvt_byte_type rdata_ff;
	logic         rd_hit_ff;
	logic [11:0]  base;
	logic         sel_idx;
	logic         sel_dat;
	logic         idx_local;

	// Base follows misc output bit 0
	assign base    = MISC_COLOR_SEL_I ? HVT_BASE_COLOR : HVT_BASE_MONO;
	assign sel_idx = IO_ADDR_I == {base, HVT_PORT_INDEX};
	assign sel_dat = IO_ADDR_I == {base, HVT_PORT_DATA};
	assign idx_local = idx_ff <= HVT_IDX_LAST;
	assign EXT_IDX_SEL_O = !idx_local;
	assign EXT_INDEX_O   = idx_ff;

	// Index register, full eight bits kept
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			idx_ff <= HVT_INDEX_RST;
		end else if (IO_WR_I && sel_idx) begin
			idx_ff <= IO_WDATA_I;
		end
	end

	// Timing registers written through the data port
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			for (int i = 0; i < HVT_NUM_REGS; i++) begin
				regs_ff[i] <= HVT_REG_RST;
			end
		end else if (IO_WR_I && sel_dat && idx_local) begin
			regs_ff[idx_ff[2:0]] <= IO_WDATA_I;
		end
	end

	// Read data one cycle after the strobe; foreign indices stay silent
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			rdata_ff  <= 8'h00;
			rd_hit_ff <= 1'b0;
		end else begin
			rd_hit_ff <= IO_RD_I && (sel_idx || (sel_dat && idx_local));
			if (IO_RD_I && sel_idx) begin
				rdata_ff <= idx_ff;
			end else if (IO_RD_I && sel_dat && idx_local) begin
				rdata_ff <= regs_ff[idx_ff[2:0]];
			end else begin
				rdata_ff <= 8'h00;
			end
		end
	end

	assign IO_RDATA_O  = rdata_ff;
	assign IO_RD_HIT_O = rd_hit_ff;

	// ----------------------------------------------------------------
	// Assembled fields
	// ----------------------------------------------------------------
	hvt_byte_type ovfl;
	hvt_hcnt_type htot;
	hvt_hcnt_type hde;
	hvt_hcnt_type hbs;
	hvt_hcnt_type hss;
	logic [5:0]   hbe;
	logic [4:0]   hse;
	hvt_vcnt_type vtot;
	hvt_vcnt_type vrs;

	assign ovfl = regs_ff[HVT_IDX_OVFL[2:0]];
	assign htot = {HORIZ_EXT_I[HVT_HX_HTOT8], regs_ff[HVT_IDX_HTOT[2:0]]};
	assign hde  = {HORIZ_EXT_I[HVT_HX_HDE8], regs_ff[HVT_IDX_HDE[2:0]]};
	assign hbs  = {HORIZ_EXT_I[HVT_HX_HBS8], regs_ff[HVT_IDX_HBS[2:0]]};
	assign hss  = {HORIZ_EXT_I[HVT_HX_HSS8], regs_ff[HVT_IDX_HSS[2:0]]};
	assign hbe  = {regs_ff[HVT_IDX_HSE[2:0]][HVT_HBE_B5],
		regs_ff[HVT_IDX_HBE[2:0]][4:0]};
	assign hse  = regs_ff[HVT_IDX_HSE[2:0]][4:0];
	// Overflow bits extend the vertical fields
	assign vtot = {VERT_EXT_I[HVT_VX_VTOT10], ovfl[HVT_OV_VTOT9],
		ovfl[HVT_OV_VTOT8], regs_ff[HVT_IDX_VTOT[2:0]]};
	assign vrs  = {VERT_EXT_I[HVT_VX_VRS10], ovfl[HVT_OV_VRS9],
		ovfl[HVT_OV_VRS8], VSYNC_START_LO_I};

	// ----------------------------------------------------------------
	// Counters
	// ----------------------------------------------------------------
	logic [2:0]   pix_cnt_ff;
	logic         char_en;
	hvt_hcnt_type char_cnt_ff;
	hvt_vcnt_type line_cnt_ff;
	logic         line_end;
	logic         frame_end;

	assign char_en   = PIXEL_CLK_EN_I && pix_cnt_ff == HVT_PIX_LAST;
	assign line_end  = {1'b0, char_cnt_ff} == {1'b0, htot} + HVT_HTOT_ADJ;
	assign frame_end = {1'b0, line_cnt_ff} == {1'b0, vtot} + HVT_VTOT_ADJ;

	// Character clock divider from the pixel clock enable
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			pix_cnt_ff <= 3'h0;
		end else if (PIXEL_CLK_EN_I) begin
			pix_cnt_ff <= pix_cnt_ff + 3'h1;
		end
	end

	// Character counter; a total lowered below the count wraps at 511
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			char_cnt_ff <= 9'h000;
		end else if (char_en) begin
			char_cnt_ff <= line_end ? 9'h000 : char_cnt_ff + 9'h001;
		end
	end

	// Scan line counter
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			line_cnt_ff <= 11'h000;
		end else if (char_en && line_end) begin
			line_cnt_ff <= frame_end ? 11'h000 : line_cnt_ff + 11'h001;
		end
	end

	assign CHAR_CNT_O = char_cnt_ff;
	assign LINE_CNT_O = line_cnt_ff;

	// ----------------------------------------------------------------
	// Horizontal pulses
	// ----------------------------------------------------------------
	logic de_raw_ff;
	logic hblank_raw;
	logic hsync_raw;
	logic vsync_ff;

	// Display enable from the counter, before skew
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			de_raw_ff <= 1'b0;
		end else if (char_en) begin
			de_raw_ff <= (line_end ? 9'h000 : char_cnt_ff + 9'h001) <= hde;
		end
	end

	// Blank pulse with 64-pixel stretch
	hvt_pulse #(.EW(6), .STR(HVT_BLANK_STR)) u_blank (
		.clk_i     (SYS_CLK_I),
		.rst_n_i   (RST_N_I),
		.char_en_i (char_en),
		.pix_en_i  (PIXEL_CLK_EN_I),
		.cnt_i     (char_cnt_ff),
		.start_i   (hbs),
		.end_i     (hbe),
		.stretch_i (HORIZ_EXT_I[HVT_HX_BSTR]),
		.pulse_o   (hblank_raw)
	);

	// Sync pulse with 32-pixel stretch
	hvt_pulse #(.EW(5), .STR(HVT_SYNC_STR)) u_sync (
		.clk_i     (SYS_CLK_I),
		.rst_n_i   (RST_N_I),
		.char_en_i (char_en),
		.pix_en_i  (PIXEL_CLK_EN_I),
		.cnt_i     (char_cnt_ff),
		.start_i   (hss),
		.end_i     (hse),
		.stretch_i (HORIZ_EXT_I[HVT_HX_SSTR]),
		.pulse_o   (hsync_raw)
	);

	// Display enable skew
	hvt_skew u_de_skew (
		.clk_i     (SYS_CLK_I),
		.rst_n_i   (RST_N_I),
		.char_en_i (char_en),
		.d_i       (de_raw_ff),
		.sel_i     (regs_ff[HVT_IDX_HBE[2:0]][HVT_SKEW_LSB+:2]),
		.q_o       (DISP_EN_O)
	);

	// Sync skew, centres the picture
	hvt_skew u_hs_skew (
		.clk_i     (SYS_CLK_I),
		.rst_n_i   (RST_N_I),
		.char_en_i (char_en),
		.d_i       (hsync_raw),
		.sel_i     (regs_ff[HVT_IDX_HSE[2:0]][HVT_SKEW_LSB+:2]),
		.q_o       (HSYNC_O)
	);

	// Blank output registered for clean edges
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			HBLANK_O <= 1'b0;
		end else begin
			HBLANK_O <= hblank_raw;
		end
	end

	// ----------------------------------------------------------------
	// Vertical sync
	// ----------------------------------------------------------------
	// Start at retrace line, end on four-bit match of the line count
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			vsync_ff <= 1'b0;
		end else if (char_en && line_end) begin
			if (frame_end ? vrs == 11'h000 : vrs == line_cnt_ff + 11'h001) begin
				vsync_ff <= 1'b1;
			end else if (vsync_ff && (frame_end ? VSYNC_END_I == 4'h0
				: VSYNC_END_I == 4'(line_cnt_ff + 11'h001))) begin
				vsync_ff <= 1'b0;
			end
		end
	end

	assign VSYNC_O = vsync_ff;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_idx_wr;
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		IO_WR_I && sel_idx |=> idx_ff == $past(IO_WDATA_I);
	endproperty
	a_idx_wr: assert property (p_idx_wr)
		else $error("index write not stored");

	property p_base;
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		IO_WR_I && MISC_COLOR_SEL_I
			&& IO_ADDR_I == {HVT_BASE_MONO, HVT_PORT_INDEX}
			|=> $stable(idx_ff);
	endproperty
	a_base: assert property (p_base)
		else $error("mono port decoded in colour mode");

	property p_ext;
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		IO_RD_I && sel_dat && idx_ff > HVT_IDX_LAST |=> !IO_RD_HIT_O;
	endproperty
	a_ext: assert property (p_ext)
		else $error("foreign index answered locally");

	property p_hwrap;
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		char_en && {1'b0, char_cnt_ff} == {1'b0, htot} + HVT_HTOT_ADJ
			|=> char_cnt_ff == 9'h000;
	endproperty
	a_hwrap: assert property (p_hwrap)
		else $error("char counter did not wrap");

	property p_vwrap;
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		char_en && line_end && frame_end |=> line_cnt_ff == 11'h000;
	endproperty
	a_vwrap: assert property (p_vwrap)
		else $error("line counter did not wrap");

	property p_de;
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		char_en && !line_end && char_cnt_ff == hde |=> !de_raw_ff;
	endproperty
	a_de: assert property (p_de)
		else $error("display enable past display end");

	property p_hbl;
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		char_en && char_cnt_ff == hbs |=> hblank_raw ##1 HBLANK_O;
	endproperty
	a_hbl: assert property (p_hbl)
		else $error("blank not started");

	property p_hbe;
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		hblank_raw && char_en && char_cnt_ff[5:0] == hbe
			&& char_cnt_ff != hbs && !HORIZ_EXT_I[HVT_HX_BSTR]
			&& !u_blank.str_ff |=> !hblank_raw;
	endproperty
	a_hbe: assert property (p_hbe)
		else $error("blank not ended");

	property p_hsy;
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		char_en && char_cnt_ff == hss |=> hsync_raw;
	endproperty
	a_hsy: assert property (p_hsy)
		else $error("sync not started");

	property p_vs;
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		char_en && line_end && !frame_end && vrs == line_cnt_ff + 11'h001
			|=> VSYNC_O;
	endproperty
	a_vs: assert property (p_vs)
		else $error("vertical sync not started");

	c_line: cover property (@(posedge SYS_CLK_I) char_en && line_end);
	c_frame: cover property (@(posedge SYS_CLK_I) char_en && frame_end);
	c_hsync: cover property (@(posedge SYS_CLK_I) $rose(HSYNC_O));
	c_vsync: cover property (@(posedge SYS_CLK_I) $rose(VSYNC_O));
endmodule : hvt_timing

// >>> hvt_host.sv
// Host processor model that drives the block's I/O port
module hvt_host (
	// Clock
	input  wire logic             clk_i,
	// I/O strobes towards the block
	output hvt_pkg::hvt_addr_type addr_o,
	output logic                  wr_o,
	output logic                  rd_o,
	output hvt_pkg::hvt_byte_type wdata_o
);
	timeunit 1ns;
	timeprecision 100ps;
	import hvt_pkg::*;

	// ----------------------------------------------------------------
	// Bus idle state
	// ----------------------------------------------------------------
	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 16'h0000;
		wdata_o = 8'h00;
	end

	// ----------------------------------------------------------------
	// Single access
	// ----------------------------------------------------------------
	// Strobe stands one edge; released lines show inverse, never stale
	task automatic acc(input logic w, input hvt_addr_type a,
		input hvt_byte_type d);
		@(posedge clk_i);
		#2;
		addr_o = a;
		wdata_o = d;
		wr_o = w;
		rd_o = !w;
		@(posedge clk_i);
		#2;
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~d;
	endtask : acc
endmodule : hvt_host

// >>> testbench.sv
// Self-checking testbench for the raster timing block
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import hvt_pkg::*;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic         clk = 1'b0;
	logic         rst_n = 1'b0;
	hvt_addr_type addr;
	logic         wr;
	logic         rd;
	hvt_byte_type wdata;
	hvt_byte_type rdata;
	logic         hit;
	logic         ext_sel;
	hvt_byte_type ext_idx;
	logic         misc = 1'b1;
	hvt_byte_type hext = 8'h00;
	hvt_byte_type vext = 8'h00;
	hvt_byte_type vs_lo = 8'h02;
	logic [3:0]   vs_end = 4'h4;
	logic         pix_en = 1'b1;
	logic         hs;
	logic         hb;
	logic         de;
	logic         vs;
	hvt_hcnt_type ccnt;
	hvt_vcnt_type lcnt;
	int           bad_count = 0;
	int           tests_run = 0;
	int           cyc = 0;
	logic [31:0]  seed = 32680;
	hvt_byte_type expq[$];
	hvt_byte_type shadow[8];

	// Clock at 40 MHz
	always #12.5 clk = ~clk;

	hvt_timing DUT (
		.SYS_CLK_I(clk), .RST_N_I(rst_n), .IO_ADDR_I(addr),
		.IO_WR_I(wr), .IO_RD_I(rd), .IO_WDATA_I(wdata),
		.IO_RDATA_O(rdata), .IO_RD_HIT_O(hit), .EXT_IDX_SEL_O(ext_sel),
		.EXT_INDEX_O(ext_idx), .MISC_COLOR_SEL_I(misc),
		.HORIZ_EXT_I(hext), .VERT_EXT_I(vext),
		.VSYNC_START_LO_I(vs_lo), .VSYNC_END_I(vs_end),
		.PIXEL_CLK_EN_I(pix_en), .HSYNC_O(hs), .HBLANK_O(hb),
		.DISP_EN_O(de), .VSYNC_O(vs), .CHAR_CNT_O(ccnt),
		.LINE_CNT_O(lcnt)
	);

	hvt_host u_host (
		.clk_i(clk), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata)
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time,
				seen, exp);
		end
	endtask : check

	task automatic stop_test;
		if (bad_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	function automatic logic sig(input int s);
		case (s)
			0: return hs;
			1: return hb;
			2: return de;
			default: return vs;
		endcase
	endfunction : sig

	function automatic hvt_addr_type base();
		return misc ? 16'h03D0 : 16'h03B0;
	endfunction : base

	task automatic tick;
		@(posedge clk);
		#2;
	endtask : tick

	// Read with expected value noted for the watcher
	task automatic rd_port(input hvt_addr_type a, input hvt_byte_type e);
		expq.push_back(e);
		u_host.acc(1'b0, a, 8'h00);
	endtask : rd_port

	// Index first, then data port
	task automatic wreg(input hvt_byte_type i, input hvt_byte_type v);
		u_host.acc(1'b1, base() | 16'h4, i);
		u_host.acc(1'b1, base() | 16'h5, v);
	endtask : wreg

	task automatic rreg(input hvt_byte_type i, input hvt_byte_type e);
		u_host.acc(1'b1, base() | 16'h4, i);
		rd_port(base() | 16'h5, e);
	endtask : rreg

	// Offset of a rise from a line start, then its high time
	task automatic meas(input int s, output int r, output int w);
		hvt_vcnt_type p;
		r = 0;
		w = 0;
		// Start from low so a pulse already running is not measured
		while (sig(s) === 1'b1)
			tick();
		p = lcnt;
		while (lcnt === p)
			tick();
		while (sig(s) !== 1'b1) begin
			tick();
			r++;
		end
		while (sig(s) === 1'b1) begin
			tick();
			w++;
		end
	endtask : meas

	// ----------------------------------------------------------------
	// Read watcher: oldest note against each answered read
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (hit === 1'b1) begin
			if (expq.size() == 0)
				check(32'h1, 32'h0);
			else
				check(rdata, expq.pop_front());
		end
	end

	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			bad_count++;
			stop_test();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		int r0, r1, w, n, mx, mc;
		repeat (2) @(posedge clk);
		#2;
		rst_n = 1'b1;
		// Reset values, then random fill and reverse-order readback
		rd_port(16'h03D4, 8'h00);
		for (int i = 0; i < HVT_NUM_REGS; i++)
			rreg(8'(i), HVT_REG_RST);
		for (int i = 0; i < HVT_NUM_REGS; i++) begin
			shadow[i] = 8'(rnd());
			wreg(8'(i), shadow[i]);
		end
		for (int i = HVT_NUM_REGS - 1; i >= 0; i--)
			rreg(8'(i), shadow[i]);
		// Wrong base ignored, then mono base answers
		u_host.acc(1'b1, 16'h03B4, 8'h05);
		rd_port(16'h03D4, 8'h00);
		misc = 1'b0;
		rreg(8'h03, shadow[3]);
		u_host.acc(1'b0, 16'h03D5, 8'h00);
		check(hit, 1'b0);
		misc = 1'b1;
		// Index beyond local range goes to other blocks
		u_host.acc(1'b1, 16'h03D4, 8'h07);
		check(ext_sel, 1'b0);
		u_host.acc(1'b1, 16'h03D4, 8'h20);
		check(ext_sel, 1'b1);
		check(ext_idx, 8'h20);
		u_host.acc(1'b0, 16'h03D5, 8'h00);
		check(hit, 1'b0);
		// Raster: 32 chars per line, 6 lines per frame
		wreg(HVT_IDX_HTOT, 8'd27);
		wreg(HVT_IDX_HDE, 8'd9);
		wreg(HVT_IDX_HBS, 8'd12);
		wreg(HVT_IDX_HBE, 8'd17);
		wreg(HVT_IDX_HSS, 8'd13);
		wreg(HVT_IDX_HSE, 8'd16);
		wreg(HVT_IDX_VTOT, 8'd4);
		wreg(HVT_IDX_OVFL, 8'h00);
		meas(0, r0, w);
		meas(0, r0, w);
		check(w, 24);
		meas(1, r1, w);
		check(w, 40);
		meas(2, r1, w);
		check(w, 80);
		n = 0;
		meas(2, r1, w);
		while (lcnt !== 11'(0) || n == 0) begin
			tick();
			n++;
		end
		mx = 0;
		mc = 0;
		for (int i = 0; i < 1536 * 2; i++) begin
			tick();
			if (int'(lcnt) > mx)
				mx = int'(lcnt);
			if (int'(ccnt) > mc)
				mc = int'(ccnt);
		end
		check(mx, 5);
		check(mc, 31);
		n = 0;
		r1 = int'(lcnt);
		while (int'(lcnt) == r1)
			tick();
		r1 = int'(lcnt);
		while (int'(lcnt) == r1) begin
			tick();
			n++;
		end
		check(n, 256);
		meas(3, r1, w);
		check(w, 512);
		// Overflow bit 2 moves retrace start beyond the frame
		wreg(HVT_IDX_OVFL, 8'h04);
		while (lcnt !== 11'(0))
			tick();
		n = 0;
		for (int i = 0; i < 1536; i++) begin
			tick();
			if (vs !== 1'b0)
				n++;
		end
		check(n, 0);
		// Start position and skews move the rise by whole chars
		wreg(HVT_IDX_HSS, 8'd14);
		meas(0, r1, w);
		check(r1 - r0, 8);
		wreg(HVT_IDX_HSS, 8'd13);
		wreg(HVT_IDX_HSE, 8'h70);
		meas(0, r1, w);
		check(r1 - r0, 24);
		check(w, 24);
		meas(2, r0, w);
		check(r0, 1);
		wreg(HVT_IDX_HBE, 8'h51);
		meas(2, r1, w);
		check(r1 - r0, 16);
		// Stretch bits
		hext = 8'h28;
		meas(0, r1, w);
		check(w, 24 + HVT_SYNC_STR);
		meas(1, r1, w);
		check(w, 40 + HVT_BLANK_STR);
		repeat (4) tick();
		check(expq.size(), 0);
		stop_test();
	end
endmodule : testbench
